// File: hdl/two_level_interrupt_controller.sv
// two-level priority interrupt controller with five sources
//
// Behaviour
// - serial unit requests on every transmitted frame and every error-free received frame
// - a received frame with errors raises no serial request
// - two levels; each source set high or low in the priority register
// - an enabled high request preempts a running low routine
// - a running high routine is never preempted until its return
// - same level ties go ext0, timer0, ext1, timer1, serial
// - flags sampled each machine cycle, samples polled the next one
// - an accepted request makes the core do a long call to its vector
// - no vectoring while a same or higher level routine runs
// - vector only in the last machine cycle of an instruction
// - no vectoring during a return or a write to enable or priority
// - blocked requests are not remembered; each poll uses fresh samples
// - priority bits 0..4 ext0, timer0, ext1, timer1, serial; 1 is high
// - enable bits 0..4 per source, bit 7 global gate, 5..6 unused
// - each external pin is falling edge or low level by its trigger bit
// - edge flag cleared on vectoring; level flag follows the pin
// - timer overflow flag cleared when its routine is vectored
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_map.svh"

module two_level_interrupt_controller (
    input  wire logic        clock_in,              // core clock, 25 MHz
    input  wire logic        reset_in,              // async reset, high
    input  wire logic        ce_in,                 // clock enable, freezes all but the call and clear pulses
    input  wire logic        mc_end_in,             // last clock of a machine cycle
    input  wire logic        last_cycle_in,         // machine cycle ends instruction
    input  wire logic        return_from_irq_in,    // instruction is a return
    input  wire logic [7:0]  sfr_addr_in,           // special register address
    input  wire logic        sfr_wr_in,             // special register write
    input  wire logic [7:0]  sfr_wdata_in,          // write data
    input  wire logic        sfr_rd_in,             // special register read
    output logic      [7:0]  sfr_rdata_out,         // read data
    output logic             sfr_hit_out,           // address is ours
    input  wire logic        ext0_pin_in,           // external pin 0
    input  wire logic        ext1_pin_in,           // external pin 1
    input  wire logic        ext0_trigger_type_in,  // 1 falling edge, 0 low level
    input  wire logic        ext1_trigger_type_in,  // 1 falling edge, 0 low level
    input  wire logic        timer0_overflow_in,    // timer 0 rollover pulse
    input  wire logic        timer1_overflow_in,    // timer 1 rollover pulse
    input  wire logic        rx_frame_done_in,      // serial frame received
    input  wire logic        rx_frame_error_in,     // received frame has errors
    input  wire logic        tx_frame_done_in,      // serial frame sent
    input  wire logic        serial_flag_clear_in,  // software clears serial flag
    output logic      [4:0]  request_flags_out,     // live request flags
    output logic             call_req_out,          // inject long call, one pulse
    output logic      [15:0] call_vector_out,       // call target
    output logic      [1:0]  active_level_out       // routines in progress
);

    irq_ctrl_pkg::ctrl_state_type st_ff;
    irq_ctrl_pkg::ctrl_state_type nxt_st;

    irq_flag_if fl ();

    logic [4:0] gated;
    logic [4:0] high_req;
    logic [4:0] low_req;
    logic [4:0] grant;
    logic       grant_high;
    logic       blocked;
    logic       ie_hit;
    logic       ip_hit;

    // lowest index wins within a level
    function automatic logic [4:0] pick_first(input logic [4:0] req);
        logic [4:0] one;
        one = 5'h00;
        for (int i = `SRC_COUNT - 1; i >= 0; i--) begin
            if (req[i]) begin
                one = 5'h01 << i;
            end
        end
        return one;
    endfunction

    function automatic logic [15:0] vector_of(input logic [4:0] one);
        logic [15:0] v;
        v = `VEC_NONE;
        if (one[`SRC_EXT0]) begin
            v = `VEC_EXT0;
        end else if (one[`SRC_TIMER0]) begin
            v = `VEC_TIMER0;
        end else if (one[`SRC_EXT1]) begin
            v = `VEC_EXT1;
        end else if (one[`SRC_TIMER1]) begin
            v = `VEC_TIMER1;
        end else if (one[`SRC_SERIAL]) begin
            v = `VEC_SERIAL;
        end
        return v;
    endfunction

    irq_flag_sampler u_sampler (
        .clock_in             (clock_in),
        .reset_in             (reset_in),
        .ce_in                (ce_in),
        .ext0_pin_in          (ext0_pin_in),
        .ext1_pin_in          (ext1_pin_in),
        .ext0_trigger_type_in (ext0_trigger_type_in),
        .ext1_trigger_type_in (ext1_trigger_type_in),
        .timer0_overflow_in   (timer0_overflow_in),
        .timer1_overflow_in   (timer1_overflow_in),
        .rx_frame_done_in     (rx_frame_done_in),
        .rx_frame_error_in    (rx_frame_error_in),
        .tx_frame_done_in     (tx_frame_done_in),
        .serial_flag_clear_in (serial_flag_clear_in),
        .fl                   (fl.sampler)
    );

    assign fl.clear = st_ff.clear;

    // address decode
    always_comb begin
        ie_hit = 1'b0;
        ip_hit = 1'b0;
        if (sfr_addr_in == `ENABLE_SFR_ADDR) begin
            ie_hit = 1'b1;
        end else if (sfr_addr_in == `PRIORITY_SFR_ADDR) begin
            ip_hit = 1'b1;
        end
    end

    // polled view of the previous cycle's samples
    always_comb begin
        gated = st_ff.sampled & st_ff.enable[`SOURCE_FIELD] &
                {`SRC_COUNT{st_ff.enable[`GLOBAL_GATE_BIT]}};
        high_req = gated & st_ff.prio[`SOURCE_FIELD];
        low_req = gated & ~st_ff.prio[`SOURCE_FIELD];
        // return or enable/priority write in this instruction holds off
        blocked = st_ff.write_block | return_from_irq_in |
                  (sfr_wr_in & (ie_hit | ip_hit));
        grant = 5'h00;
        grant_high = 1'b0;
        case (st_ff.level)
            irq_ctrl_pkg::LVL_NONE: begin
                if (high_req != 5'h00) begin
                    grant = pick_first(high_req);
                    grant_high = 1'b1;
                end else begin
                    grant = pick_first(low_req);
                end
            end
            irq_ctrl_pkg::LVL_LOW: begin
                grant = pick_first(high_req);
                grant_high = 1'b1;
            end
            default: begin
                grant = 5'h00;
            end
        endcase
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.call = 1'b0;
        nxt_st.clear = 5'h00;
        if (ce_in) begin
            if (mc_end_in) begin
                // fresh samples every cycle, nothing held over
                nxt_st.sampled = fl.flags;
                if (last_cycle_in) begin
                    nxt_st.write_block = 1'b0;
                    if (!blocked && grant != 5'h00) begin
                        nxt_st.call = 1'b1;
                        nxt_st.vector = vector_of(grant);
                        nxt_st.clear = grant;
                        if (grant_high) begin
                            if (st_ff.level == irq_ctrl_pkg::LVL_LOW) begin
                                nxt_st.level = irq_ctrl_pkg::LVL_BOTH;
                            end else begin
                                nxt_st.level = irq_ctrl_pkg::LVL_HIGH;
                            end
                        end else begin
                            nxt_st.level = irq_ctrl_pkg::LVL_LOW;
                        end
                    end else if (return_from_irq_in) begin
                        case (st_ff.level)
                            irq_ctrl_pkg::LVL_BOTH: begin
                                nxt_st.level = irq_ctrl_pkg::LVL_LOW;
                            end
                            default: begin
                                nxt_st.level = irq_ctrl_pkg::LVL_NONE;
                            end
                        endcase
                    end
                end
            end
            if (sfr_wr_in) begin
                if (ie_hit) begin
                    nxt_st.enable = sfr_wdata_in & `ENABLE_USED_MASK;
                    nxt_st.write_block = !(mc_end_in && last_cycle_in);
                end else if (ip_hit) begin
                    nxt_st.prio = sfr_wdata_in & `PRIORITY_USED_MASK;
                    nxt_st.write_block = !(mc_end_in && last_cycle_in);
                end
            end
            if (sfr_rd_in) begin
                if (ie_hit) begin
                    nxt_st.rdata = st_ff.enable;
                end else if (ip_hit) begin
                    nxt_st.rdata = st_ff.prio;
                end else begin
                    nxt_st.rdata = 8'h00;
                end
            end
        end
    end

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            st_ff <= '{sampled: 5'h00, enable: `ENABLE_RESET, prio: `PRIORITY_RESET,
                       level: irq_ctrl_pkg::LVL_NONE, write_block: 1'b0, call: 1'b0,
                       vector: `VEC_NONE, clear: 5'h00, rdata: 8'h00};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign sfr_rdata_out = st_ff.rdata;
    assign sfr_hit_out = ie_hit | ip_hit;
    assign request_flags_out = fl.flags;
    assign call_req_out = st_ff.call;
    assign call_vector_out = st_ff.vector;
    assign active_level_out = st_ff.level;

endmodule

`default_nettype wire

// File: hdl/irq_ctrl_map.svh
// constant map of the two-level interrupt controller
`ifndef IRQ_CTRL_MAP_SVH
`define IRQ_CTRL_MAP_SVH

`define SRC_COUNT        5
`define SRC_EXT0         0
`define SRC_TIMER0       1
`define SRC_EXT1         2
`define SRC_TIMER1       3
`define SRC_SERIAL       4

`define ENABLE_SFR_ADDR  8'hA8
`define PRIORITY_SFR_ADDR 8'hB8
`define ENABLE_RESET     8'h00
`define PRIORITY_RESET   8'h00
`define ENABLE_USED_MASK 8'h9F
`define PRIORITY_USED_MASK 8'h1F
`define GLOBAL_GATE_BIT  7
`define SOURCE_FIELD     4:0

`define VEC_EXT0         16'h0003
`define VEC_TIMER0       16'h000B
`define VEC_EXT1         16'h0013
`define VEC_TIMER1       16'h001B
`define VEC_SERIAL       16'h0023
`define VEC_NONE         16'h0000

`endif

// File: hdl/irq_ctrl_pkg.sv
// types shared by the interrupt controller modules
package irq_ctrl_pkg;

    typedef enum logic [1:0] {
        LVL_NONE,
        LVL_LOW,
        LVL_HIGH,
        LVL_BOTH
    } level_type;

    typedef struct packed {
        logic [4:0]  sampled;
        logic [7:0]  enable;
        logic [7:0]  prio;
        level_type   level;
        logic        write_block;
        logic        call;
        logic [15:0] vector;
        logic [4:0]  clear;
        logic [7:0]  rdata;
    } ctrl_state_type;

    typedef struct packed {
        logic [1:0] sync1;
        logic [1:0] sync2;
        logic [1:0] last;
        logic [4:0] flag;
    } flag_state_type;

endpackage

// File: hdl/irq_flag_if.sv
// flag and clear carrier between flag sampler and arbiter
`timescale 1ns/1ps
`default_nettype none

interface irq_flag_if;
    logic [4:0] flags;
    logic [4:0] clear;

    modport sampler (
        output flags,
        input  clear
    );

    modport arbiter (
        input  flags,
        output clear
    );
endinterface

`default_nettype wire

// File: hdl/irq_flag_sampler.sv
// request flag keeping for the five interrupt sources
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_map.svh"

module irq_flag_sampler (
    input  wire logic        clock_in,              // core clock
    input  wire logic        reset_in,              // async reset, high
    input  wire logic        ce_in,                 // clock enable
    input  wire logic        ext0_pin_in,           // external pin 0
    input  wire logic        ext1_pin_in,           // external pin 1
    input  wire logic        ext0_trigger_type_in,  // 1 edge, 0 level
    input  wire logic        ext1_trigger_type_in,  // 1 edge, 0 level
    input  wire logic        timer0_overflow_in,    // timer 0 rollover pulse
    input  wire logic        timer1_overflow_in,    // timer 1 rollover pulse
    input  wire logic        rx_frame_done_in,      // frame received pulse
    input  wire logic        rx_frame_error_in,     // received frame bad
    input  wire logic        tx_frame_done_in,      // frame sent pulse
    input  wire logic        serial_flag_clear_in,  // software clears serial flag
    irq_flag_if.sampler      fl                     // flags out, clears in
);

    irq_ctrl_pkg::flag_state_type st_ff;
    irq_ctrl_pkg::flag_state_type nxt_st;

    logic [1:0] trig;
    logic [1:0] fall;

    assign trig = {ext1_trigger_type_in, ext0_trigger_type_in};
    assign fl.flags = st_ff.flag;

    always_comb begin
        nxt_st = st_ff;
        fall = st_ff.last & ~st_ff.sync2;
        if (ce_in) begin
            nxt_st.sync1 = {ext1_pin_in, ext0_pin_in};
            nxt_st.sync2 = st_ff.sync1;
            nxt_st.last = st_ff.sync2;
            // edge mode: falling edge sets, vectoring clears, set wins
            if (trig[0]) begin
                nxt_st.flag[`SRC_EXT0] = fall[0] |
                    (st_ff.flag[`SRC_EXT0] & ~fl.clear[`SRC_EXT0]);
            end else begin
                nxt_st.flag[`SRC_EXT0] = ~st_ff.sync2[0];
            end
            if (trig[1]) begin
                nxt_st.flag[`SRC_EXT1] = fall[1] |
                    (st_ff.flag[`SRC_EXT1] & ~fl.clear[`SRC_EXT1]);
            end else begin
                nxt_st.flag[`SRC_EXT1] = ~st_ff.sync2[1];
            end
            nxt_st.flag[`SRC_TIMER0] = timer0_overflow_in |
                (st_ff.flag[`SRC_TIMER0] & ~fl.clear[`SRC_TIMER0]);
            nxt_st.flag[`SRC_TIMER1] = timer1_overflow_in |
                (st_ff.flag[`SRC_TIMER1] & ~fl.clear[`SRC_TIMER1]);
            // bad received frames raise nothing
            nxt_st.flag[`SRC_SERIAL] = tx_frame_done_in |
                (rx_frame_done_in & ~rx_frame_error_in) |
                (st_ff.flag[`SRC_SERIAL] & ~serial_flag_clear_in);
        end
    end

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            st_ff <= '{sync1: 2'h3, sync2: 2'h3, last: 2'h3, flag: 5'h00};
        end else begin
            st_ff <= nxt_st;
        end
    end

endmodule

`default_nettype wire

// File: bench/irq_ctrl_properties.sv
// port checker for the two-level interrupt controller
`timescale 1ns/1ps
`default_nettype none

module irq_ctrl_checker (
    input wire logic        clock_in,
    input wire logic        reset_in,
    input wire logic        ce_in,
    input wire logic        mc_end_in,
    input wire logic        last_cycle_in,
    input wire logic        return_from_irq_in,
    input wire logic        ext0_pin_in,
    input wire logic        ext0_trigger_type_in,
    input wire logic        timer0_overflow_in,
    input wire logic        rx_frame_done_in,
    input wire logic        rx_frame_error_in,
    input wire logic        tx_frame_done_in,
    input wire logic [4:0]  request_flags_out,
    input wire logic        call_req_out,
    input wire logic [15:0] call_vector_out,
    input wire logic [1:0]  active_level_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (reset_in);

    property p_poll_edge;
        call_req_out |-> $past(mc_end_in && last_cycle_in && ce_in);
    endproperty
    a_poll_edge: assert property (p_poll_edge)
        else $error("call away from an instruction end");
    property p_no_ret;
        call_req_out |-> !$past(return_from_irq_in);
    endproperty
    a_no_ret: assert property (p_no_ret)
        else $error("call during a return");
    property p_high_held;
        call_req_out |-> !$past(active_level_out[1]);
    endproperty
    a_high_held: assert property (p_high_held)
        else $error("high routine was preempted");
    property p_low_nest;
        call_req_out && $past(active_level_out) == 2'h1 |-> active_level_out == 2'h3;
    endproperty
    a_low_nest: assert property (p_low_nest)
        else $error("low routine preempted by a low request");
    property p_vector;
        call_req_out |-> call_vector_out inside {16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023};
    endproperty
    a_vector: assert property (p_vector)
        else $error("call to an unknown target");
    property p_timer_clear;
        call_req_out && call_vector_out == 16'h000B && !timer0_overflow_in |=> !request_flags_out[1];
    endproperty
    a_timer_clear: assert property (p_timer_clear)
        else $error("timer flag kept after vectoring");
    property p_serial_set;
        ce_in && (tx_frame_done_in || rx_frame_done_in && !rx_frame_error_in)
            |=> request_flags_out[4];
    endproperty
    a_serial_set: assert property (p_serial_set)
        else $error("serial flag not raised");
    property p_level_pin;
        (ce_in && !ext0_trigger_type_in && !ext0_pin_in)[*4] |-> request_flags_out[0];
    endproperty
    a_level_pin: assert property (p_level_pin)
        else $error("level flag not following the pin");
endmodule

bind two_level_interrupt_controller irq_ctrl_checker chk (
    .clock_in, .reset_in, .ce_in, .mc_end_in, .last_cycle_in, .return_from_irq_in,
    .ext0_pin_in, .ext0_trigger_type_in, .timer0_overflow_in, .rx_frame_done_in,
    .rx_frame_error_in, .tx_frame_done_in, .request_flags_out, .call_req_out,
    .call_vector_out, .active_level_out
);

`default_nettype wire

// File: bench/core_model.sv
// behavioural core: machine cycle framing and return instructions
`timescale 1ns/1ps
`default_nettype none

module core_model (
    input  wire logic clock_in,   // core clock
    input  wire logic reset_in,   // async reset, high
    input  wire logic long_in,    // instructions take two machine cycles
    input  wire logic ret_req_in, // pulse: a return follows
    output logic      mc_end_out, // last clock of a machine cycle
    output logic      last_out,   // machine cycle ends the instruction
    output logic      ret_out     // return instruction running
);
    logic [1:0] phase;
    logic       second;
    logic       pend;

    always @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            phase   <= 2'h0;
            second  <= 1'b0;
            pend    <= 1'b0;
            ret_out <= 1'b0;
        end else begin
            phase <= phase + 2'h1;
            if (mc_end_out) begin
                second <= !last_out;
                if (last_out) begin
                    ret_out <= pend;
                    pend    <= 1'b0;
                end
            end
            if (ret_req_in)
                pend <= 1'b1;
        end
    end

    assign mc_end_out = (phase == 2'h3);
    assign last_out   = !long_in || second;
endmodule

`default_nettype wire

// File: bench/two_level_interrupt_controller_test.sv
// self-checking bench for the two-level interrupt controller
`timescale 1ns/1ps
`default_nettype none

module two_level_interrupt_controller_test;
    logic        clock_in  = 1'b0;
    logic        reset_in  = 1'b1;
    logic        long_ins  = 1'b0;
    logic        ret_req   = 1'b0;
    logic        sfr_wr    = 1'b0;
    logic        sfr_rd    = 1'b0;
    logic        rx_done   = 1'b0;
    logic        rx_err    = 1'b0;
    logic        tx_done   = 1'b0;
    logic        sclr      = 1'b0;
    logic [7:0]  sfr_addr  = 8'h00;
    logic [7:0]  sfr_wdata = 8'h00;
    logic [1:0]  pins      = 2'h3;
    logic [1:0]  trig      = 2'h3;
    logic [1:0]  tov       = 2'h0;
    logic        mc_end, last_cycle, ret_irq, call;
    logic        hit;
    logic        ce        = 1'b1;
    logic [7:0]  rdata;
    logic [4:0]  flags, m, p;
    logic [15:0] vector;
    logic [1:0]  level;
    logic [17:0] exp;
    logic [17:0] notes[$];
    int          err_count   = 0;
    int          check_count = 0;

    two_level_interrupt_controller DUT (
        .clock_in(clock_in), .reset_in(reset_in), .ce_in(ce),
        .mc_end_in(mc_end), .last_cycle_in(last_cycle), .return_from_irq_in(ret_irq),
        .sfr_addr_in(sfr_addr), .sfr_wr_in(sfr_wr), .sfr_wdata_in(sfr_wdata),
        .sfr_rd_in(sfr_rd), .sfr_rdata_out(rdata), .sfr_hit_out(hit),
        .ext0_pin_in(pins[0]), .ext1_pin_in(pins[1]),
        .ext0_trigger_type_in(trig[0]), .ext1_trigger_type_in(trig[1]),
        .timer0_overflow_in(tov[0]), .timer1_overflow_in(tov[1]),
        .rx_frame_done_in(rx_done), .rx_frame_error_in(rx_err), .tx_frame_done_in(tx_done),
        .serial_flag_clear_in(sclr), .request_flags_out(flags), .call_req_out(call),
        .call_vector_out(vector), .active_level_out(level)
    );

    core_model core (
        .clock_in(clock_in), .reset_in(reset_in), .long_in(long_ins), .ret_req_in(ret_req),
        .mc_end_out(mc_end), .last_out(last_cycle), .ret_out(ret_irq)
    );

    initial forever #20 clock_in = ~clock_in;

    task automatic tick(input int n = 1);
        repeat (n) @(posedge clock_in);
    endtask

    task automatic check(input logic [17:0] seen, input logic [17:0] e);
        check_count++;
        if (seen !== e) begin
            err_count++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, e);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic sfr(input logic wr, input logic [7:0] a, input logic [7:0] d);
        sfr_addr  <= a;
        sfr_wdata <= d;
        sfr_wr    <= wr;
        sfr_rd    <= !wr;
        tick();
        sfr_wr <= 1'b0;
        sfr_rd <= 1'b0;
        tick();
    endtask

    // falling pin edges, timer rollovers and a sent frame in one cycle
    task automatic raise(input logic [4:0] s);
        pins    <= ~{s[2], s[0]};
        tov     <= {s[3], s[1]};
        tx_done <= s[4];
        tick();
        pins    <= 2'h3;
        tov     <= 2'h0;
        tx_done <= 1'b0;
        tick();
    endtask

    task automatic drain();
        repeat (300) if (notes.size() != 0) tick();
        check(18'(notes.size()), 18'h0);
    endtask

    task automatic ret(input logic [1:0] lv);
        ret_req <= 1'b1;
        tick();
        ret_req <= 1'b0;
        repeat (100) if (level !== lv) tick();
        check(level, lv);
    endtask

    task automatic serve(input int i, input logic hi);
        notes.push_back({hi ? 2'h2 : 2'h1, 16'h0003 + 16'(i) * 16'h0008});
        drain();
        if (i == 4) begin
            sclr <= 1'b1;
            tick();
            sclr <= 1'b0;
        end
        ret(2'h0);
    endtask

    // every call must match the oldest expected one
    always @(posedge clock_in) begin
        if (call === 1'b1) begin
            exp = (notes.size() != 0) ? notes.pop_front() : 18'h3FFFF;
            check({level, vector}, exp);
        end
    end

    initial begin
        repeat (20000) @(posedge clock_in);
        err_count++;
        finish_test();
    end

    initial begin
        void'($urandom(17));
        repeat (6) @(posedge clock_in);
        reset_in <= 1'b0;
        tick(2);
        sfr(0, 8'hA8, 8'h00);
        check(rdata, 8'h00);
        sfr(0, 8'hB8, 8'h00);
        check(rdata, 8'h00);
        sfr(1, 8'hA8, 8'hFF);
        sfr(1, 8'hB8, 8'hFF);
        sfr(1, 8'h99, 8'hFF);
        sfr(0, 8'hA8, 8'h00);
        check(rdata, 8'h9F);
        sfr(0, 8'hB8, 8'h00);
        check(rdata, 8'h1F);
        check(hit, 1'b1);
        sfr(0, 8'h99, 8'h00);
        check(rdata, 8'h00);
        check(hit, 1'b0);
        $display("register test done");
        sfr(1, 8'hA8, 8'h00);
        rx_done <= 1'b1;
        rx_err  <= 1'b1;
        tick();
        rx_done <= 1'b0;
        rx_err  <= 1'b0;
        tick();
        check(flags[4], 1'b0);
        rx_done <= 1'b1;
        tick();
        rx_done <= 1'b0;
        tick();
        check(flags[4], 1'b1);
        sclr <= 1'b1;
        tick();
        sclr <= 1'b0;
        tick();
        $display("serial flag test done");
        trig <= 2'h2;
        sfr(1, 8'hA8, 8'h01);
        pins <= 2'h2;
        tick(40);
        check(flags[0], 1'b1);
        pins <= 2'h3;
        tick(8);
        sfr(1, 8'hA8, 8'h81);
        tick(40);
        check(flags[0], 1'b0);
        trig <= 2'h3;
        // rollover while frozen is not taken
        ce  <= 1'b0;
        tov <= 2'h1;
        tick();
        tov <= 2'h0;
        ce  <= 1'b1;
        tick(2);
        check(flags[1], 1'b0);
        $display("gate test done");
        sfr(1, 8'hB8, 8'h02);
        sfr(1, 8'hA8, 8'h9F);
        notes.push_back({2'h1, 16'h0013});
        raise(5'h04);
        drain();
        notes.push_back({2'h3, 16'h000B});
        raise(5'h02);
        drain();
        raise(5'h01);
        tick(40);
        ret(2'h1);
        tick(40);
        notes.push_back({2'h1, 16'h0003});
        ret(2'h0);
        drain();
        ret(2'h0);
        $display("nesting test done");
        for (int r = 0; r < 6; r++) begin
            m = 5'($urandom);
            p = 5'($urandom);
            long_ins <= 1'($urandom);
            sfr(1, 8'hA8, 8'h1F);
            sfr(1, 8'hB8, {3'h0, p});
            raise(m);
            tick(4);
            sfr(1, 8'hA8, 8'h9F);
            for (int lv = 1; lv >= 0; lv--)
                for (int i = 0; i < 5; i++)
                    if (m[i] && p[i] == lv[0])
                        serve(i, lv[0]);
        end
        $display("polling order test done");
        finish_test();
    end
endmodule

`default_nettype wire
